// ===== src/uls_regs.vh
// uls_regs.vh: register offsets, field positions, reset values and timing counts
// assumes: included by the design files of the line status block, 100 MHz clock
//
// Summary of operation
// - transmit-holding-empty (bit 5) sets when a character moves to the shift register
// - transmit-holding-empty clears in the cycle after the host writes a character
// - fifo mode: bit 5 high while transmit fifo empty, clears on first byte
// - bit 5 high with thr irq enable and irq mask bit 0 both set raises the interrupt request
// - break flag (bit 4) sets when serial input stays low a whole frame
// - fifo mode: a break of any length stores exactly one break character
// - framing error (bit 3) sets when the stop bit is not high
// - fifo mode: parity and framing flags follow the character at fifo head
// - parity error (bit 2) sets when received parity mismatches configured parity
// - overrun (bit 1) sets when a character completes while the fifo (or, fifo off, the holding register) is full
// - on overrun the shift register is overwritten, the fifo is left unchanged
// - data ready (bit 0) high while a received character waits, else low
// - reset clears break, framing, parity, overrun and data ready flags
// - bit 7 high while any fifo character carries a parity, framing or break error
// - bit 6 high when transmit fifo/holding and shift register are both empty
`ifndef ULS_REGS_VH
`define ULS_REGS_VH

// ***************************************************************
// register byte addresses
// ***************************************************************
`define ULS_ADDR_RX_DATA     12'h000
`define ULS_ADDR_TX_DATA     12'h004
`define ULS_ADDR_LINE_STATUS 12'h008
`define ULS_ADDR_CONTROL     12'h00C
`define ULS_ADDR_IRQ_STATUS  12'h010
`define ULS_ADDR_IRQ_MASK    12'h014

// ***************************************************************
// line status fields
// ***************************************************************
`define ULS_LS_READY     0
`define ULS_LS_OVERRUN   1
`define ULS_LS_PARITY    2
`define ULS_LS_FRAMING   3
`define ULS_LS_BREAK     4
`define ULS_LS_THR_EMPTY 5
`define ULS_LS_TX_EMPTY  6
`define ULS_LS_FIFO_ERR  7

// control fields: fifo enable, parity enable, even parity, thr irq enable
`define ULS_CTL_FIFO_EN  0
`define ULS_CTL_PAR_EN   1
`define ULS_CTL_PAR_EVEN 2
`define ULS_CTL_THR_IE   3
`define ULS_CTL_RESET    4'h0

// interrupt status fields
`define ULS_IRQ_THR      0
`define ULS_IRQ_RX       1
`define ULS_IRQ_LINE     2
`define ULS_IRQ_RESET    3'h0

// ***************************************************************
// timing: bit time in ns and its cycle count
// ***************************************************************
`define ULS_CLK_NS       10
`define ULS_BIT_NS       8680
`define ULS_BIT_CYCLES   (`ULS_BIT_NS / `ULS_CLK_NS)

`endif

// ===== src/uls_fifo.v
// uls_fifo.v: synchronous fifo used for transmit and receive characters
// assumes: one clock, push ignored when full unless a pop comes in the same cycle, pop ignored when empty
`include "uls_regs.vh"

module uls_fifo #(
    parameter WIDTH = 11,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    // clock and reset
    input  wire             clk,
    input  wire             rst,
    // control
    input  wire             flush,
    input  wire             push,
    input  wire [WIDTH-1:0] push_data,
    input  wire             pop,
    // status
    output wire [WIDTH-1:0] head,
    output wire             empty,
    output wire             full,
    output wire [AW:0]      count
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      fill;
    wire            do_push;
    wire            do_pop;

    // a pop in the same cycle frees the slot, so a full fifo still takes the push
    assign do_push = push && ((fill != DEPTH[AW:0]) || pop);
    assign do_pop  = pop && (fill != {(AW+1){1'b0}});
    assign head    = mem[rd_ptr];
    assign empty   = (fill == {(AW+1){1'b0}});
    assign full    = (fill == DEPTH[AW:0]);
    assign count   = fill;

    always @(posedge clk) begin
        if (do_push) begin
            mem[wr_ptr] <= push_data;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            fill   <= {(AW+1){1'b0}};
        end else if (flush) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            fill   <= {(AW+1){1'b0}};
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (do_push && !do_pop) begin
                fill <= fill + 1'b1;
            end else if (do_pop && !do_push) begin
                fill <= fill - 1'b1;
            end
        end
    end
endmodule

// ===== src/uls_rx.v
// uls_rx.v: 8n1/8p1 receiver producing a character with its error bits
// assumes: rxd synchronous to clk, idle high, bit time is a parameter
`include "uls_regs.vh"

module uls_rx #(
    parameter BIT_CYCLES = `ULS_BIT_CYCLES
) (
    // clock and reset
    input  wire       clk,
    input  wire       rst,
    // line and format
    input  wire       rxd,
    input  wire       par_en,
    input  wire       par_even,
    // character out: one-cycle pulse
    output reg        done,
    output reg  [7:0] data,
    output reg        par_err,
    output reg        frm_err,
    output reg        brk
);
    localparam S_IDLE  = 4'b0001;
    localparam S_BITS  = 4'b0010;
    localparam S_STOP  = 4'b0100;
    localparam S_BRKW  = 4'b1000;

    reg [3:0]  state;
    reg [15:0] tick;
    reg [3:0]  nbit;
    reg [8:0]  shift;
    reg        any_one;
    wire [3:0] nbits;
    wire       par_calc;

    assign nbits    = par_en ? 4'h9 : 4'h8;
    assign par_calc = ^shift[7:0] ^ ~par_even;

    // a frame ending low waits for the line to rise: one break char, no false start
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state   <= S_IDLE;
            tick    <= 16'h0000;
            nbit    <= 4'h0;
            shift   <= 9'h000;
            any_one <= 1'b0;
            done    <= 1'b0;
            data    <= 8'h00;
            par_err <= 1'b0;
            frm_err <= 1'b0;
            brk     <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state)
            S_IDLE: begin
                any_one <= 1'b0;
                nbit    <= 4'h0;
                if (!rxd) begin
                    tick  <= BIT_CYCLES[15:0] + BIT_CYCLES[16:1];
                    state <= S_BITS;
                end
            end
            S_BITS: begin
                if (tick == 16'h0000) begin
                    tick    <= BIT_CYCLES[15:0] - 16'h0001;
                    any_one <= any_one | rxd;
                    if (nbit == 4'h8) begin
                        shift[8] <= rxd;
                    end else begin
                        shift[nbit[2:0]] <= rxd;
                    end
                    nbit <= nbit + 4'h1;
                    if (nbit + 4'h1 == nbits) begin
                        state <= S_STOP;
                    end
                end else begin
                    tick <= tick - 16'h0001;
                end
            end
            S_STOP: begin
                if (tick == 16'h0000) begin
                    done    <= 1'b1;
                    data    <= shift[7:0];
                    par_err <= par_en && (shift[8] != par_calc);
                    frm_err <= !rxd;
                    brk     <= !rxd && !any_one;
                    state   <= !rxd ? S_BRKW : S_IDLE;
                end else begin
                    tick <= tick - 16'h0001;
                end
            end
            S_BRKW: begin
                if (rxd) begin
                    state <= S_IDLE;
                end
            end
            default: state <= S_IDLE;
            endcase
        end
    end
endmodule

// ===== src/uls_top.v
// uls_top.v: line status flags of one serial channel with apb registers
// assumes: apb master on clk, rxd synchronous, tx shifter drains at bit rate
`include "uls_regs.vh"

module uls_top #(
    parameter DEPTH      = 32,
    parameter AW         = 5,
    parameter BIT_CYCLES = `ULS_BIT_CYCLES
) (
    // clock and reset
    input  wire        clk,
    input  wire        rst,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // serial line
    input  wire        rxd,
    output reg         txd,
    // interrupt
    output reg         irq
);
    // ***************************************************************
    // state
    // ***************************************************************
    localparam T_IDLE = 2'b01;
    localparam T_SEND = 2'b10;

    reg  [3:0]  control;
    reg  [2:0]  irq_status;
    reg  [2:0]  irq_mask;
    reg         overrun;
    reg         ls_par;
    reg         ls_frm;
    reg         ls_brk;
    reg  [7:0]  rx_hold;
    reg         rx_hold_full;
    reg  [7:0]  rx_shift;
    reg  [7:0]  transmit_holding_register;
    reg         thr_full;
    reg  [1:0]  tstate;
    reg  [9:0]  tx_sr;
    reg  [3:0]  tx_n;
    reg  [15:0] tx_tick;
    reg  [AW:0] err_count;

    wire        rx_done;
    wire [7:0]  rx_data;
    wire        rx_perr;
    wire        rx_ferr;
    wire        rx_brk;
    wire [10:0] rxf_head;
    wire        rxf_empty;
    wire        rxf_full;
    wire [7:0]  txf_head;
    wire        txf_empty;
    wire        txf_full;
    wire        fifo_mode;
    wire        setup;
    wire        wr_en;
    wire        rd_en;
    wire        tx_load;
    wire        rx_pop;
    wire        rx_push;
    wire        ov_event;
    wire        thr_empty;
    wire        tx_empty;
    wire        head_perr;
    wire        head_ferr;
    wire        head_brk;
    wire [7:0]  line_status;
    wire        line_evt;
    wire        head_err;
    wire        push_err;

    function is_addr;
        input [11:0] a;
        input [11:0] b;
        begin
            is_addr = (a == b);
        end
    endfunction

    // ***************************************************************
    // apb decode: zero wait states, access phase answers at once
    // ***************************************************************
    assign setup     = psel && !penable;
    assign wr_en     = psel && penable && pwrite;
    assign rd_en     = psel && penable && !pwrite;
    assign fifo_mode = control[`ULS_CTL_FIFO_EN];

    // ***************************************************************
    // transmit side
    // ***************************************************************
    uls_fifo #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) u_txf (
        .clk       (clk),
        .rst       (rst),
        .flush     (!fifo_mode),
        .push      (wr_en && fifo_mode && is_addr(paddr, `ULS_ADDR_TX_DATA)),
        .push_data (pwdata[7:0]),
        .pop       (tx_load && fifo_mode),
        .head      (txf_head),
        .empty     (txf_empty),
        .full      (txf_full),
        .count     ()
    );

    assign tx_load   = (tstate == T_IDLE) && (fifo_mode ? !txf_empty : thr_full);
    assign thr_empty = fifo_mode ? txf_empty : !thr_full;
    assign tx_empty  = thr_empty && (tstate == T_IDLE) && !tx_load;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            transmit_holding_register      <= 8'h00;
            thr_full <= 1'b0;
            tstate   <= T_IDLE;
            tx_sr    <= 10'h3FF;
            tx_n     <= 4'h0;
            tx_tick  <= 16'h0000;
            txd      <= 1'b1;
        end else begin
            // a host write in the load cycle wins, so thr_full stays set
            if (wr_en && !fifo_mode && is_addr(paddr, `ULS_ADDR_TX_DATA)) begin
                transmit_holding_register      <= pwdata[7:0];
                thr_full <= 1'b1;
            end else if (tx_load && !fifo_mode) begin
                thr_full <= 1'b0;
            end
            case (tstate)
            T_IDLE: begin
                txd <= 1'b1;
                if (tx_load) begin
                    tx_sr   <= {1'b1, fifo_mode ? txf_head : transmit_holding_register, 1'b0};
                    tx_n    <= 4'h0;
                    tx_tick <= 16'h0000;
                    tstate  <= T_SEND;
                end
            end
            T_SEND: begin
                if (tx_tick == 16'h0000) begin
                    txd     <= tx_sr[0];
                    tx_sr   <= {1'b1, tx_sr[9:1]};
                    tx_tick <= BIT_CYCLES[15:0] - 16'h0001;
                    tx_n    <= tx_n + 4'h1;
                    if (tx_n == 4'hA) begin
                        tstate <= T_IDLE;
                    end
                end else begin
                    tx_tick <= tx_tick - 16'h0001;
                end
            end
            default: tstate <= T_IDLE;
            endcase
        end
    end

    // ***************************************************************
    // receive side
    // ***************************************************************
    uls_rx #(.BIT_CYCLES(BIT_CYCLES)) u_rx (
        .clk      (clk),
        .rst      (rst),
        .rxd      (rxd),
        .par_en   (control[`ULS_CTL_PAR_EN]),
        .par_even (control[`ULS_CTL_PAR_EVEN]),
        .done     (rx_done),
        .data     (rx_data),
        .par_err  (rx_perr),
        .frm_err  (rx_ferr),
        .brk      (rx_brk)
    );

    assign rx_pop   = rd_en && is_addr(paddr, `ULS_ADDR_RX_DATA);
    assign ov_event = rx_done && (fifo_mode ? (rxf_full && !rx_pop) : (rx_hold_full && !rx_pop));
    assign rx_push  = rx_done && fifo_mode && !ov_event;

    uls_fifo #(.WIDTH(11), .DEPTH(DEPTH), .AW(AW)) u_rxf (
        .clk       (clk),
        .rst       (rst),
        .flush     (!fifo_mode),
        .push      (rx_push),
        .push_data ({rx_brk, rx_ferr, rx_perr, rx_data}),
        .pop       (rx_pop && fifo_mode),
        .head      (rxf_head),
        .empty     (rxf_empty),
        .full      (rxf_full),
        .count     ()
    );

    assign head_perr = !rxf_empty && rxf_head[8];
    assign head_ferr = !rxf_empty && rxf_head[9];
    assign head_brk  = !rxf_empty && rxf_head[10];
    assign head_err  = head_perr || head_ferr || head_brk;
    assign push_err  = rx_push && (rx_perr || rx_ferr || rx_brk);

    // count of stored characters with an error drives the fifo error bit
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            err_count <= {(AW+1){1'b0}};
        end else if (!fifo_mode) begin
            err_count <= {(AW+1){1'b0}};
        end else if (push_err && !(rx_pop && head_err)) begin
            err_count <= err_count + 1'b1;
        end else if (!push_err && rx_pop && head_err) begin
            err_count <= err_count - 1'b1;
        end
    end

    assign line_status = {
        err_count != {(AW+1){1'b0}},
        tx_empty,
        thr_empty,
        fifo_mode ? head_brk  : ls_brk,
        fifo_mode ? head_ferr : ls_frm,
        fifo_mode ? head_perr : ls_par,
        overrun,
        fifo_mode ? !rxf_empty : rx_hold_full
    };

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_hold      <= 8'h00;
            rx_hold_full <= 1'b0;
            rx_shift     <= 8'h00;
            overrun      <= 1'b0;
            ls_par       <= 1'b0;
            ls_frm       <= 1'b0;
            ls_brk       <= 1'b0;
        end else begin
            if (rx_done) begin
                rx_shift <= rx_data;
            end
            if (rx_done && !fifo_mode && !ov_event) begin
                rx_hold      <= rx_data;
                rx_hold_full <= 1'b1;
            end else if (rx_pop) begin
                rx_hold_full <= 1'b0;
            end
            // a new event in the read cycle wins over the clear
            if (ov_event) begin
                overrun <= 1'b1;
            end else if (rd_en && is_addr(paddr, `ULS_ADDR_LINE_STATUS)) begin
                overrun <= 1'b0;
            end
            if (rx_done && !fifo_mode && !ov_event) begin
                ls_par <= rx_perr;
                ls_frm <= rx_ferr;
                ls_brk <= rx_brk;
            end else if (rd_en && is_addr(paddr, `ULS_ADDR_LINE_STATUS)) begin
                ls_par <= 1'b0;
                ls_frm <= 1'b0;
                ls_brk <= 1'b0;
            end
        end
    end

    // ***************************************************************
    // registers, sticky interrupt status and apb answer
    // ***************************************************************
    assign line_evt = ov_event || (rx_done && (rx_perr || rx_ferr || rx_brk));

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            control    <= `ULS_CTL_RESET;
            irq_status <= `ULS_IRQ_RESET;
            irq_mask   <= `ULS_IRQ_RESET;
            prdata     <= 32'h0000_0000;
            pready     <= 1'b0;
            pslverr    <= 1'b0;
            irq        <= 1'b0;
        end else begin
            if (wr_en && is_addr(paddr, `ULS_ADDR_CONTROL)) begin
                control <= pwdata[3:0];
            end
            if (wr_en && is_addr(paddr, `ULS_ADDR_IRQ_MASK)) begin
                irq_mask <= pwdata[2:0];
            end
            irq_status[`ULS_IRQ_THR] <= (thr_empty && control[`ULS_CTL_THR_IE]) ||
                (irq_status[`ULS_IRQ_THR] &&
                 !(wr_en && is_addr(paddr, `ULS_ADDR_IRQ_STATUS) && pwdata[0]));
            irq_status[`ULS_IRQ_RX] <= rx_done ||
                (irq_status[`ULS_IRQ_RX] &&
                 !(wr_en && is_addr(paddr, `ULS_ADDR_IRQ_STATUS) && pwdata[1]));
            irq_status[`ULS_IRQ_LINE] <= line_evt ||
                (irq_status[`ULS_IRQ_LINE] &&
                 !(wr_en && is_addr(paddr, `ULS_ADDR_IRQ_STATUS) && pwdata[2]));
            irq     <= |(irq_status & irq_mask);
            pready  <= setup;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (setup && !pwrite) begin
                case (paddr)
                `ULS_ADDR_RX_DATA:     prdata <= {24'h000000, fifo_mode ? rxf_head[7:0] : rx_hold};
                `ULS_ADDR_LINE_STATUS: prdata <= {24'h000000, line_status};
                `ULS_ADDR_CONTROL:     prdata <= {28'h0000000, control};
                `ULS_ADDR_IRQ_STATUS:  prdata <= {29'h00000000, irq_status};
                `ULS_ADDR_IRQ_MASK:    prdata <= {29'h00000000, irq_mask};
                default:               prdata <= 32'h0000_0000;
                endcase
            end
            if (setup && !is_addr(paddr, `ULS_ADDR_RX_DATA) && !is_addr(paddr, `ULS_ADDR_TX_DATA)
                && !is_addr(paddr, `ULS_ADDR_LINE_STATUS) && !is_addr(paddr, `ULS_ADDR_CONTROL)
                && !is_addr(paddr, `ULS_ADDR_IRQ_STATUS) && !is_addr(paddr, `ULS_ADDR_IRQ_MASK)) begin
                pslverr <= 1'b1;
            end
        end
    end
endmodule

// ===== dv/uls_line.sv
// uls_line.sv: far end of the serial line, sends frames on rxd
// assumes: idle line high, one bit lasts BC clock cycles
module uls_line #(
    parameter int BC = 8
) (
    // clock
    input wire logic clk,
    // serial line
    output logic     rxd
);
    timeunit 1ns;
    timeprecision 1ps;
    initial rxd = 1'b1;
    // ****
    // frame sender
    // ****
    // start, data lsb first, parity if pe, stop s; lo stretches a break by bit times
    task automatic send(input logic [7:0] d, input logic pe, p, s, input int lo = 0);
        logic [10:0] f;
        f = pe ? {s, p, d, 1'b0} : {1'b1, s, d, 1'b0};
        for (int i = 0; i < 12 + lo; i++) begin
            @(posedge clk);
            rxd <= i < 11 ? f[i] : (i < 11 + lo ? 1'b0 : 1'b1);
            repeat (BC - 1) @(posedge clk);
        end
    endtask
endmodule

// ===== dv/uls_top_props.sv
// uls_top_props.sv: port assertions for the line status block
// assumes: bound into uls_top, one clock, apb master keeps the bus rules
`include "uls_regs.vh"
module uls_props (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // outputs
    input wire logic        txd,
    input wire logic        irq
);
    // ****
    // properties
    // ****
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    wire rd_ls = pready && !pwrite && paddr == `ULS_ADDR_LINE_STATUS;
    chk_ready_setup: assert property (psel && !penable |=> pready)
        else $error("no pready after setup");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held too long");
    chk_err_unmapped: assert property (pready && paddr > `ULS_ADDR_IRQ_MASK
        |-> pslverr && prdata == 0) else $error("unmapped access not refused");
    chk_err_mapped: assert property (pready && paddr <= `ULS_ADDR_IRQ_MASK
        && paddr[1:0] == 0 |-> !pslverr) else $error("mapped access refused");
    chk_ls_upper: assert property (rd_ls |-> prdata[31:8] == 0)
        else $error("line status upper bits set");
    chk_tx_idle: assert property (rd_ls && prdata[6] |-> txd)
        else $error("line busy while transmitter empty");
    chk_thr_with_tx: assert property (rd_ls && prdata[6] |-> prdata[5])
        else $error("transmitter empty but holding full");
    chk_err_has_data: assert property (rd_ls && prdata[7] |-> prdata[0])
        else $error("fifo error without data");
    chk_reset_quiet: assert property ($fell(rst) |-> !irq && !pready && txd)
        else $error("outputs not idle after reset");
endmodule

bind uls_top uls_props u_uls_props (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .txd(txd), .irq(irq)
);

// ===== dv/uls_top_tb.sv
// uls_top_tb.sv: self-checking bench for the line status block
// assumes: src on the include path, uls_line drives rxd
`include "uls_regs.vh"
module uls_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BC = 8;
    localparam int DP = 32;
    logic        clk, rst, psel, penable, pwrite, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, v;
    logic        pready, pslverr, rxd, txd, irq;
    int          n_fail, samples_checked;
    uls_top #(.DEPTH(DP), .BIT_CYCLES(BC)) u_uls_top (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxd(rxd), .txd(txd), .irq(irq));
    uls_line #(.BC(BC)) u_uls_line (.clk(clk), .rxd(rxd));
    // ****
    // bus and check tasks
    // ****
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic ck(input string nm, input logic [31:0] g, e);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    // request held until pready is seen high at a rising edge; answer taken at that edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        v = prdata;
        er = pslverr;
        if (pready !== 1'b1) begin
            n_fail++;
            give_verdict();
        end
        {psel, penable} <= 2'b00;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic ls(input logic [31:0] m, e, input int t = 1);
        do apb(1'b0, `ULS_ADDR_LINE_STATUS, 32'h0);
        while ((v & m) !== e && --t > 0);
        ck("line_status", v & m, e);
    endtask
    task automatic rx(input logic [7:0] e);
        apb(1'b0, `ULS_ADDR_RX_DATA, 32'h0);
        ck("rx_data", v, {24'h0, e});
    endtask
    task automatic irqc(input logic e);
        repeat (3) @(negedge clk);
        ck("irq", {31'h0, irq}, {31'h0, e});
    endtask
    // ****
    // scenarios
    // ****
    task automatic t_reset;
        ls(32'hFF, 32'h60);
        apb(1'b0, 12'h040, 32'h0);
        ck("unmapped", {31'h0, er}, 32'h1);
        ck("unmapped_data", v, 32'h0);
        apb(1'b0, `ULS_ADDR_CONTROL, 32'h0);
        ck("control", v, 32'h0);
    endtask
    task automatic t_tx;
        wr(`ULS_ADDR_TX_DATA, 32'h55);
        repeat (3) @(negedge clk);
        ck("txd_start", {31'h0, txd}, 32'h0);
        repeat (8) @(negedge clk);
        ck("txd_bit0", {31'h0, txd}, 32'h1);
        repeat (8) @(negedge clk);
        ck("txd_bit1", {31'h0, txd}, 32'h0);
        wr(`ULS_ADDR_TX_DATA, 32'hAA);
        ls(32'h60, 32'h00);
        ls(32'h20, 32'h20, 300);
        ls(32'h60, 32'h60, 300);
        wr(`ULS_ADDR_CONTROL, 32'h9);
        wr(`ULS_ADDR_IRQ_MASK, 32'h1);
        irqc(1'b1);
        wr(`ULS_ADDR_IRQ_MASK, 32'h0);
        irqc(1'b0);
        for (int i = 0; i < 3; i++) wr(`ULS_ADDR_TX_DATA, 32'h3);
        ls(32'h20, 32'h00);
        wr(`ULS_ADDR_IRQ_STATUS, 32'h1);
        wr(`ULS_ADDR_IRQ_MASK, 32'h1);
        irqc(1'b0);
        ls(32'h20, 32'h20, 300);
        irqc(1'b1);
        wr(`ULS_ADDR_IRQ_MASK, 32'h0);
    endtask
    task automatic t_rx;
        wr(`ULS_ADDR_CONTROL, 32'h6);
        u_uls_line.send(8'hA5, 1'b1, ^8'hA5, 1'b1);
        ls(32'h1F, 32'h01);
        rx(8'hA5);
        ls(32'h01, 32'h00);
        u_uls_line.send(8'h3C, 1'b1, ~^8'h3C, 1'b1);
        ls(32'h04, 32'h04);
        ls(32'h04, 32'h00);
        rx(8'h3C);
        u_uls_line.send(8'h0F, 1'b1, ^8'h0F, 1'b0);
        ls(32'h08, 32'h08);
        rx(8'h0F);
        u_uls_line.send(8'h00, 1'b1, 1'b0, 1'b0);
        ls(32'h10, 32'h10);
        rx(8'h00);
    endtask
    task automatic t_fifo;
        wr(`ULS_ADDR_CONTROL, 32'h7);
        u_uls_line.send(8'h11, 1'b1, ~^8'h11, 1'b1);
        u_uls_line.send(8'h22, 1'b1, ^8'h22, 1'b1);
        ls(32'h84, 32'h84);
        rx(8'h11);
        ls(32'h84, 32'h00);
        rx(8'h22);
        u_uls_line.send(8'h00, 1'b1, 1'b0, 1'b0, 3);
        ls(32'h91, 32'h91);
        rx(8'h00);
        ls(32'h01, 32'h00);
        wr(`ULS_ADDR_CONTROL, 32'h1);
        for (int i = 0; i <= DP; i++) u_uls_line.send(8'(i), 1'b0, 1'b0, 1'b1);
        ls(32'h03, 32'h03);
        for (int i = 0; i < DP; i++) rx(8'(i));
        ls(32'h03, 32'h00);
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        give_verdict();
    end
    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 12'h0, 32'h0};
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_tx();
        t_rx();
        t_fifo();
        give_verdict();
    end
endmodule
